// >>> bsa_dev.sv
// Converter end: configuration registers, SAR sequencing and serial port.
// Assumes the link clock runs whenever the host resets or frames the part,
// and that the comparator decision is valid at each serial clock rising edge.
//
// Added by the designer: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps

// Behaviour
// - Each channel has its own range
// - Two mode bits pick input grouping
// - Serial clock drives shifting and conversion
// - External reference until host selects internal
// - Power down between conversions when selected
// - Twos complement default, binary when set
// - Latest coding bit applies to all channels
// - Four single-ended inputs after power-up
// - Each range resolves into 8192 codes
// - Code transitions at whole step multiples
// - Acquire, then successive approximation, then result
// - Track on edge fourteen, hold at select; the code holds on serial clock edge one
module bsa_dev (
  // Reset, in no particular clock domain.
  input wire logic rst_i,
  // Serial link.
  bsa_link_if.dev link,
  // Comparator decision: input above trial level.
  input wire logic cmp_i,
  // Analog front end controls.
  output logic [12:0] dac_o,
  output logic track_o,
  output logic [1:0] conv_ch_o,
  output logic [1:0] range_o,
  output logic [11:0] lsb_uv_o,
  output logic [1:0] mode_o,
  output logic [1:0] pm_o,
  output logic ref_int_o,
  output logic pd_o
);

  // ****************************************
  // Reset synchroniser into the link clock
  // ****************************************
  logic rst_s1_r;
  logic rst_s2_r;

  // Two flip-flops bring the reset onto the serial clock.
  always_ff @(posedge link.sclk) begin
    rst_s1_r <= rst_i;
    rst_s2_r <= rst_s1_r;
  end

  // ****************************************
  // Frame decode
  // ****************************************
  logic [4:0] cnt_r;
  logic [4:0] edge_n;
  logic in_frame;
  logic e_hold;
  logic e_sar;
  logic e_track;
  logic e_last;
  logic [15:0] ish_r;
  logic [15:0] rx_word;
  logic wr_ctrl;
  logic wr_range;

  // Number of this rising edge since select fell, counted from one.
  assign in_frame = ~link.cs_n;
  assign edge_n = cnt_r + 5'h01;
  assign e_hold = in_frame && (edge_n == bsa_pkg::EDGE_HOLD);
  assign e_sar = in_frame && (edge_n >= bsa_pkg::EDGE_SAR_FIRST) && (edge_n <= bsa_pkg::EDGE_TRACK);
  assign e_track = in_frame && (edge_n == bsa_pkg::EDGE_TRACK);
  assign e_last = in_frame && (edge_n == bsa_pkg::EDGE_LAST);
  assign rx_word = {ish_r[14:0], link.sdi};
  assign wr_ctrl = e_last && rx_word[bsa_pkg::W_BIT] && (rx_word[bsa_pkg::SEL_HI:bsa_pkg::SEL_LO] == bsa_pkg::SEL_CTRL);
  assign wr_range = e_last && rx_word[bsa_pkg::W_BIT] && (rx_word[bsa_pkg::SEL_HI:bsa_pkg::SEL_LO] == bsa_pkg::SEL_RANGE);

  // Edge counter restarts whenever select is high; input bits shift in.
  always_ff @(posedge link.sclk) begin
    if (rst_s2_r || !in_frame) begin
      cnt_r <= 5'h00;
    end else if (cnt_r != bsa_pkg::EDGE_LAST) begin
      cnt_r <= edge_n;
    end
    if (in_frame) begin
      ish_r <= rx_word;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [12:0] ctrl_r;
  logic [7:0] range_r;

  // Written only at the end of a write frame, otherwise held.
  always_ff @(posedge link.sclk) begin
    if (rst_s2_r) begin
      ctrl_r <= bsa_pkg::CTRL_RESET;
      range_r <= bsa_pkg::RANGE_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= rx_word[12:0];
      end
      if (wr_range) begin
        range_r <= rx_word[7:0];
      end
    end
  end

  // Configuration outputs follow the registers.
  always_ff @(posedge link.sclk) begin
    mode_o <= ctrl_r[bsa_pkg::MODE_HI:bsa_pkg::MODE_LO];
    pm_o <= ctrl_r[bsa_pkg::PM_HI:bsa_pkg::PM_LO];
    ref_int_o <= ctrl_r[bsa_pkg::REF_BIT];
  end

  // ****************************************
  // Successive approximation
  // ****************************************
  logic [12:0] trial_r;
  logic [12:0] mask_r;
  logic [12:0] res_r;
  logic [1:0] ch_r;
  logic [1:0] ch_rng;
  logic [12:0] decided;
  logic [12:0] trial_nxt;

  // Keep the trial bit when the input sits above it, else drop it.
  assign decided = cmp_i ? trial_r : (trial_r & ~mask_r);
  assign ch_rng = range_r[2 * ctrl_r[bsa_pkg::CH_HI:bsa_pkg::CH_LO] +: 2];
  // Trial level taken at this edge; the DAC is fed from it so the comparator never judges a stale trial.
  assign trial_nxt = rst_s2_r ? 13'h0000 :
    (e_hold ? bsa_pkg::SAR_MSB : (e_sar ? (decided | (mask_r >> 1)) : trial_r));

  // One trial bit per serial clock edge, all from the link clock.
  always_ff @(posedge link.sclk) begin
    if (rst_s2_r) begin
      trial_r <= 13'h0000;
      mask_r <= 13'h0000;
      res_r <= 13'h0000;
      ch_r <= 2'h0;
      track_o <= 1'b1;
      range_o <= bsa_pkg::RNG_PM10;
      lsb_uv_o <= bsa_pkg::LSB_UV_20V;
    end else if (e_hold) begin
      // Hold the sample and start with the top trial bit.
      track_o <= 1'b0;
      trial_r <= bsa_pkg::SAR_MSB;
      mask_r <= bsa_pkg::SAR_MSB;
      ch_r <= ctrl_r[bsa_pkg::CH_HI:bsa_pkg::CH_LO];
      range_o <= ch_rng;
      lsb_uv_o <= bsa_pkg::lsb_uv(ch_rng);
    end else if (e_sar) begin
      trial_r <= trial_nxt;
      mask_r <= mask_r >> 1;
      if (e_track) begin
        // Raw code is offset binary; flip the sign bit for twos complement.
        res_r <= ctrl_r[bsa_pkg::CODING_BIT] ? decided : (decided ^ bsa_pkg::SAR_MSB);
        track_o <= 1'b1;
      end
    end
  end

  // Trial level to the charge DAC, in step with the SAR register.
  always_ff @(posedge link.sclk) begin
    dac_o <= trial_nxt;
    conv_ch_o <= ch_r;
  end

  // ****************************************
  // Power saving between conversions
  // ****************************************
  // Low power from edge sixteen of a frame until edge one of the next, and only if the host picked it.
  always_ff @(posedge link.sclk) begin
    if (rst_s2_r || e_hold) begin
      pd_o <= 1'b0;
    end else if (e_last) begin
      pd_o <= (ctrl_r[bsa_pkg::PM_HI:bsa_pkg::PM_LO] != bsa_pkg::PM_NORMAL);
    end
  end

  // ****************************************
  // Serial data out
  // ****************************************
  logic [15:0] osh_r;
  logic [15:0] tx_word;
  logic sdo_r;

  // Result of the previous conversion, tagged with its channel.
  assign tx_word = {1'b0, ch_r, res_r};
  assign link.sdo = sdo_r;

  // One bit leaves on each rising edge, top bit first.
  always_ff @(posedge link.sclk) begin
    if (rst_s2_r) begin
      osh_r <= 16'h0000;
      sdo_r <= 1'b0;
    end else if (e_hold) begin
      sdo_r <= tx_word[15];
      osh_r <= tx_word << 1;
    end else if (in_frame) begin
      sdo_r <= osh_r[15];
      osh_r <= osh_r << 1;
    end
  end

endmodule : bsa_dev

// >>> bsa_host.sv
// Host end: Wishbone slave that sends one 16-bit frame per write.
// Assumes a 20 MHz system clock; the serial clock is a divide by four.
`timescale 1ns/1ps
module bsa_host (
  // System clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Serial link.
  bsa_link_if.host link
);

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DRAIN} bsa_st_e;

  // ****************************************
  // Serial clock divider and data return sync
  // ****************************************
  logic div_r;
  logic sclk_r;
  logic fall;
  logic rise;
  logic sdo_s1_r;
  logic sdo_s2_r;

  assign fall = div_r && sclk_r;
  assign rise = div_r && !sclk_r;
  assign link.sclk = sclk_r;

  // Free-running clock so the converter also sees reset edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 1'b0;
      sclk_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
      if (div_r) begin
        sclk_r <= ~sclk_r;
      end
    end
    sdo_s1_r <= link.sdo;
    sdo_s2_r <= sdo_s1_r;
  end

  // ****************************************
  // Frame engine
  // ****************************************
  bsa_st_e st_r;
  logic [15:0] txd_r;
  logic [15:0] sh_r;
  logic [15:0] rxd_r;
  logic [4:0] n_r;
  logic [4:0] m_r;
  logic skip_r;
  logic go_r;
  logic cs_n_r;
  logic sdi_r;
  logic wb_req;
  logic wr_tx;

  assign link.cs_n = cs_n_r;
  assign link.sdi = sdi_r;
  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wr_tx = wb_req && we_i && (adr_i == bsa_pkg::ADR_TX) && sel_i[0] && sel_i[1];

  // Bits leave on falling edges and return sampled before each rising edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ST_IDLE;
      cs_n_r <= 1'b1;
      sdi_r <= 1'b0;
      sh_r <= 16'h0000;
      rxd_r <= 16'h0000;
      n_r <= 5'h00;
      m_r <= 5'h00;
      skip_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go_r && fall) begin
            cs_n_r <= 1'b0;
            sdi_r <= txd_r[15];
            sh_r <= txd_r << 1;
            n_r <= 5'h01;
            m_r <= 5'h00;
            skip_r <= 1'b1;
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT, ST_DRAIN: begin
          if (fall && st_r == ST_SHIFT) begin
            if (n_r == bsa_pkg::EDGE_LAST) begin
              cs_n_r <= 1'b1;
              st_r <= ST_DRAIN;
            end else begin
              sdi_r <= sh_r[15];
              sh_r <= sh_r << 1;
              n_r <= n_r + 5'h01;
            end
          end
          if (rise) begin
            skip_r <= 1'b0;
            if (!skip_r) begin
              rxd_r <= {rxd_r[14:0], sdo_s2_r};
              m_r <= m_r + 5'h01;
              if (m_r == bsa_pkg::EDGE_LAST - 5'h01) begin
                st_r <= ST_IDLE;
              end
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Wishbone registers
  // ****************************************
  // One-cycle answer; writes while busy are dropped.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      go_r <= 1'b0;
      txd_r <= 16'h0000;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= wb_req;
      if (wr_tx && st_r == ST_IDLE && !go_r) begin
        txd_r <= dat_i[15:0];
        go_r <= 1'b1;
      end else if (st_r == ST_IDLE && go_r && fall) begin
        go_r <= 1'b0;
      end
      case (adr_i)
        bsa_pkg::ADR_TX: dat_o <= {16'h0000, txd_r};
        bsa_pkg::ADR_STAT: dat_o <= {31'h00000000, go_r || (st_r != ST_IDLE)};
        bsa_pkg::ADR_RX: dat_o <= {16'h0000, rxd_r};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

endmodule : bsa_host

// >>> bsa_link_asserts.sv
// Checker for the serial link between the host end and the converter end.
// Assumes it is instantiated beside the link interface with the converter's outputs.
`timescale 1ns/1ps
module bsa_link_asserts (
  // Link clock domain and converter reset.
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic rst_i,
  // Converter side signals.
  input wire logic cmp_i,
  input wire logic [12:0] dac_o,
  input wire logic track_o,
  input wire logic [1:0] range_o,
  input wire logic [11:0] lsb_uv_o,
  input wire logic [1:0] mode_o,
  input wire logic [1:0] pm_o,
  input wire logic ref_int_o,
  input wire logic pd_o
);
  // ****************************************
  // Helper logic
  // ****************************************
  logic [4:0] edge_cnt_r;

  // Counts serial clock rises seen while the part is selected.
  always_ff @(posedge sclk) begin
    if (rst_i || cs_n) begin
      edge_cnt_r <= 5'h00;
    end else begin
      edge_cnt_r <= edge_cnt_r + 5'h01;
    end
  end

  default clocking @(posedge sclk); endclocking
  default disable iff (rst_i);

  // ****************************************
  // Assertions
  // ****************************************
  chk_hold_window: assert property ((!cs_n && edge_cnt_r >= 5'h02 && edge_cnt_r <= 5'h0d) |-> !track_o)
    else $error("Sampling stage left hold during conversion.");
  chk_track_back: assert property ((!cs_n && edge_cnt_r == 5'h0d) |-> ##[1:2] track_o)
    else $error("Sampling stage did not return to track.");
  chk_sar_first: assert property ((!cs_n && edge_cnt_r == 5'h01) |-> dac_o == 13'h1000)
    else $error("First trial code is not midscale.");
  chk_sar_msb: assert property ((!cs_n && edge_cnt_r == 5'h01) |=> dac_o[12] == $past(cmp_i) && dac_o[11])
    else $error("Top bit decision not taken on the serial clock.");
  chk_pd_frame: assert property ((!cs_n && edge_cnt_r >= 5'h02) |-> !pd_o)
    else $error("Powered down during a frame.");
  chk_cfg_hold: assert property (!cs_n |-> $stable(mode_o) && $stable(pm_o) && $stable(ref_int_o))
    else $error("Configuration changed in mid frame.");
  chk_frame_len: assert property ($rose(cs_n) |-> edge_cnt_r == 5'h10)
    else $error("Frame did not last sixteen clock rises.");
  chk_lsb_range: assert property ((!cs_n && edge_cnt_r >= 5'h03 && edge_cnt_r <= 5'h0d) |->
    lsb_uv_o == (range_o == 2'h0 ? 12'h989 : (range_o == 2'h2 ? 12'h262 : 12'h4c4)))
    else $error("Step size does not match range.");
endmodule : bsa_link_asserts

// >>> bsa_link_if.sv
// Serial link between the host controller and the converter.
// Assumes the host makes the serial clock and the converter runs on it.
`timescale 1ns/1ps
interface bsa_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic sdo;

  // Host end drives clock, select and data in.
  modport host (output sclk, output cs_n, output sdi, input sdo);
  // Converter end returns serial data.
  modport dev (input sclk, input cs_n, input sdi, output sdo);
endinterface : bsa_link_if

// >>> bsa_pkg.sv
// Shared constants for the bipolar SAR converter control block and its host.
// Assumes both ends use the 16-bit serial frame defined here.
package bsa_pkg;

  // ****************************************
  // Serial frame layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam logic [4:0] EDGE_HOLD = 5'h01;
  localparam logic [4:0] EDGE_SAR_FIRST = 5'h02;
  localparam logic [4:0] EDGE_TRACK = 5'h0e;
  localparam logic [4:0] EDGE_LAST = 5'h10;
  localparam int W_BIT = 15;
  localparam int SEL_HI = 14;
  localparam int SEL_LO = 13;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_RANGE = 2'h1;

  // ****************************************
  // Control word fields and reset values
  // ****************************************
  localparam int CH_HI = 12;
  localparam int CH_LO = 11;
  localparam int MODE_HI = 10;
  localparam int MODE_LO = 9;
  localparam int PM_HI = 8;
  localparam int PM_LO = 7;
  localparam int CODING_BIT = 6;
  localparam int REF_BIT = 5;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
  localparam logic [7:0] RANGE_RESET = 8'h00;
  localparam logic [1:0] MODE_SINGLE4 = 2'h0;
  localparam logic [1:0] PM_NORMAL = 2'h0;

  // ****************************************
  // Ranges, code size and step sizes in microvolts
  // ****************************************
  localparam int RES_BITS = 13;
  localparam int CODES = 8192;
  localparam logic [1:0] RNG_PM10 = 2'h0;
  localparam logic [1:0] RNG_PM5 = 2'h1;
  localparam logic [1:0] RNG_PM2P5 = 2'h2;
  localparam logic [1:0] RNG_UNI10 = 2'h3;
  localparam logic [11:0] LSB_UV_20V = 12'h989;
  localparam logic [11:0] LSB_UV_10V = 12'h4c4;
  localparam logic [11:0] LSB_UV_5V = 12'h262;
  localparam logic [12:0] SAR_MSB = 13'h1000;

  // Step size of one code for a range.
  function automatic logic [11:0] lsb_uv(input logic [1:0] rng);
    case (rng)
      RNG_PM10: lsb_uv = LSB_UV_20V;
      RNG_PM2P5: lsb_uv = LSB_UV_5V;
      default: lsb_uv = LSB_UV_10V;
    endcase
  endfunction : lsb_uv

  // ****************************************
  // Host register map, byte addresses
  // ****************************************
  localparam logic [3:0] ADR_TX = 4'h0;
  localparam logic [3:0] ADR_STAT = 4'h4;
  localparam logic [3:0] ADR_RX = 4'h8;

endpackage : bsa_pkg

// >>> tb_bipolar_sar_adc_config_control.sv
// Testbench joining the host end and the converter end over the serial link.
// Assumes a 20 MHz system clock; the comparator is modelled from the trial code.
`timescale 1ns/1ps
module tb_bipolar_sar_adc_config_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic dev_rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic cmp_i = 1'b0;
  logic [12:0] dac_o;
  logic track_o, ref_int_o, pd_o;
  logic [1:0] conv_ch_o, range_o, mode_o, pm_o;
  logic [11:0] lsb_uv_o;
  logic [12:0] vin_code = 13'h0000;
  logic [12:0] vin_tab [4] = '{13'h0000, 13'h1fff, 13'h1000, 13'h0fff};
  logic [11:0] lsb_tab [4] = '{12'h989, 12'h4c4, 12'h262, 12'h4c4};
  logic [1:0] kk;
  logic [15:0] rx;
  logic [31:0] rd;
  int n_fail = 0;
  int check_count = 0;

  // ****************************************
  // Design, link and checker
  // ****************************************
  bsa_link_if i_bsa_link_if ();
  bsa_host i_bsa_host (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .link(i_bsa_link_if.host));
  bsa_dev i_bsa_dev (.rst_i(dev_rst_i), .link(i_bsa_link_if.dev), .cmp_i(cmp_i), .dac_o(dac_o), .track_o(track_o),
    .conv_ch_o(conv_ch_o), .range_o(range_o), .lsb_uv_o(lsb_uv_o), .mode_o(mode_o), .pm_o(pm_o),
    .ref_int_o(ref_int_o), .pd_o(pd_o));
  bsa_link_asserts i_bsa_link_asserts (.sclk(i_bsa_link_if.sclk), .cs_n(i_bsa_link_if.cs_n), .rst_i(dev_rst_i),
    .cmp_i(cmp_i), .dac_o(dac_o), .track_o(track_o), .range_o(range_o), .lsb_uv_o(lsb_uv_o), .mode_o(mode_o),
    .pm_o(pm_o), .ref_int_o(ref_int_o), .pd_o(pd_o));

  // Makes the 50 ns system clock.
  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // Comparator: the input sits half a step above vin_code, so the code lands on vin_code.
  always @(posedge clk_i) begin
    cmp_i <= (dac_o <= vin_code);
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One classic Wishbone cycle; waits for ack under a bound.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    i = 0;
    do begin
      @(posedge clk_i);
      i++;
    end while (ack_o !== 1'b1 && i < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    sel_i <= 4'h0;
    if (i >= 50) begin
      n_fail++;
      $display("ERROR %0t bus answer missing", $time);
      final_report();
    end
  endtask : wb

  // Sends one frame, waits until idle and returns the bits received.
  task automatic send_frame(input logic [15:0] f, output logic [15:0] rx_o);
    int n;
    logic [31:0] r;
    wb(1'b1, bsa_pkg::ADR_TX, {16'h0000, f}, r);
    n = 0;
    r = 32'h1;
    while (r[0] !== 1'b0 && n < 100) begin
      wb(1'b0, bsa_pkg::ADR_STAT, 32'h0, r);
      n++;
    end
    if (r[0] !== 1'b0) begin
      n_fail++;
      $display("ERROR %0t frame never finished", $time);
      final_report();
    end
    wb(1'b0, bsa_pkg::ADR_RX, 32'h0, r);
    rx_o = r[15:0];
  endtask : send_frame

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (32) @(posedge clk_i);
    dev_rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    check(32'(mode_o), 32'h0, "grouping after reset");
    check(32'(ref_int_o), 32'h0, "reference after reset");
    check(32'(pd_o), 32'h0, "power down after reset");
    wb(1'b0, 4'hc, 32'h0, rd);
    check(rd, 32'h0, "unmapped read");
    // Ranges: channel k gets range code k.
    send_frame(16'ha0e4, rx);
    for (int k = 0; k < 4; k++) begin
      kk = k[1:0];
      vin_code = vin_tab[k];
      send_frame({1'b1, 2'h0, kk, kk, kk, kk[0], kk[1], 5'h00}, rx);
      check(32'(mode_o), 32'(kk), "grouping");
      check(32'(ref_int_o), 32'(kk[1]), "reference");
      send_frame(16'h0000, rx);
      check(32'(range_o), 32'(kk), "range");
      check(32'(conv_ch_o), 32'(kk), "channel converted");
      check(32'(lsb_uv_o), 32'(lsb_tab[k]), "step size");
      check(32'(pd_o), 32'(kk != 2'h0), "power down");
      send_frame(16'h0000, rx);
      check(32'(rx), 32'({1'b0, kk, kk[0] ? vin_tab[k] : vin_tab[k] ^ 13'h1000}), "result");
      check(32'(pm_o), 32'(kk), "settings kept");
    end
    // A second write while busy is ignored.
    wb(1'b1, bsa_pkg::ADR_TX, 32'h00008200, rd);
    send_frame(16'h8400, rx);
    check(32'(mode_o), 32'h1, "write while busy");
    final_report();
  end
endmodule : tb_bipolar_sar_adc_config_control
